/* File: dv/i2c_host_model.sv */
// Behavioural two-wire host that clocks SCL and pulls SDA for register transfers
`timescale 1ns/10ps

module i2c_host_model #(
    parameter logic [6:0] TARGET_ADDR = 7'h02
) (
    // Clock
    input wire logic ref_clk,
    // Two-wire lines, SDA released means pulled up
    input wire logic sdaLine,
    output logic sclOut,
    output logic sdaDrv
);
    int nackCount = 0;
    // Bus idles released
    initial begin
        sclOut = 1'b1;
        sdaDrv = 1'b1;
    end
    // Wait a number of clock edges
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // One bit out, SCL low and high eight cycles each
    task automatic bitOut(input logic b);
        sdaDrv <= b;
        tick(4);
        sclOut <= 1'b1;
        tick(8);
        sclOut <= 1'b0;
        tick(4);
    endtask
    // One bit in, sampled mid-high
    task automatic bitIn(output logic b);
        sdaDrv <= 1'b1;
        tick(4);
        sclOut <= 1'b1;
        tick(4);
        b = sdaLine;
        tick(4);
        sclOut <= 1'b0;
        tick(4);
    endtask
    // Start or repeated start
    task automatic startCond();
        sdaDrv <= 1'b1;
        tick(4);
        sclOut <= 1'b1;
        tick(8);
        sdaDrv <= 1'b0;
        tick(8);
        sclOut <= 1'b0;
        tick(4);
    endtask
    // Stop, leaving the bus released
    task automatic stopCond();
        sdaDrv <= 1'b0;
        tick(4);
        sclOut <= 1'b1;
        tick(8);
        sdaDrv <= 1'b1;
        tick(8);
    endtask
    // Byte out MSB first, then the target's acknowledge
    task automatic byteOut(input logic [7:0] d, input logic countNack);
        logic a;
        for (int i = 7; i >= 0; i--) bitOut(d[i]);
        bitIn(a);
        if (countNack && a) nackCount++;
    endtask
    // Pointer write followed by zero to seven data bytes
    task automatic writeReg(input logic [7:0] ptr, input logic [55:0] data, input logic [2:0] n);
        startCond();
        byteOut({TARGET_ADDR, 1'b0}, 1'b1);
        byteOut(ptr, 1'b0);
        for (int k = n - 1; k >= 0; k--) byteOut(data[8*k+:8], 1'b0);
        stopCond();
    endtask
    // Pointer write, repeated start, four bytes in, last one refused
    task automatic readReg(input logic [7:0] ptr, output logic [31:0] data);
        logic b;
        startCond();
        byteOut({TARGET_ADDR, 1'b0}, 1'b1);
        byteOut(ptr, 1'b0);
        startCond();
        byteOut({TARGET_ADDR, 1'b1}, 1'b1);
        for (int i = 31; i >= 0; i--) begin
            bitIn(b);
            data[i] = b;
            if (i % 8 == 0) bitOut(i == 0);
        end
        stopCond();
    endtask
endmodule

/* File: dv/sensor_result_and_key_regs_tb_top.sv */
// Self-checking bench for the result and key registers
`timescale 1ns/10ps
`include "sensor_regs_map.svh"

module sensor_result_and_key_regs_tb_top;
    import sensor_regs_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic resultUpdate = 1'b0;
    result_set_t resultIn = '0;
    result_set_t resExp = '0;
    logic sclLine, sdaDrv, sdaOut, sdaOe, autoMode, convReq, convDone, cfgWe;
    wire logic sdaLine = sdaDrv & ~(sdaOe & ~sdaOut);
    int seed = 32'h404b2ecd;
    int err_count = 0;
    int num_checks = 0;
    int convReqCount = 0;
    logic [31:0] word;
    // Clock
    always #4 ref_clk = ~ref_clk;
    // Count request pulses from status writes, unknowns included
    always @(negedge ref_clk) begin
        if (convReq !== 1'b0) convReqCount++;
    end
    // Device and host
    sensor_result_and_key_regs uut (.ref_clk(ref_clk), .reset(reset), .sclIn(sclLine),
        .sdaIn(sdaLine), .sdaOut_q(sdaOut), .sdaOe_q(sdaOe), .resultUpdate(resultUpdate),
        .resultIn(resultIn), .autoMode_q(autoMode), .convRequest_q(convReq),
        .convDone_q(convDone), .configWriteEnable_q(cfgWe));
    i2c_host_model host (.ref_clk(ref_clk), .sdaLine(sdaLine), .sclOut(sclLine),
        .sdaDrv(sdaDrv));
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Word expected from a pointer
    function automatic logic [31:0] expReg(input logic [7:0] ptr);
        case (ptr)
            `REG_PRES_VALUE: return resExp.compPres;
            `REG_TEMP_VALUE: return resExp.compTemp;
            `REG_RAW_PRES: return resExp.rawPres;
            `REG_RAW_TEMP: return resExp.rawTemp;
            default: return `WORD_ZERO;
        endcase
    endfunction
    // Engine delivers a fresh random result set
    task automatic newResults();
        @(posedge ref_clk);
        resExp = {$random(seed), $random(seed), $random(seed), $random(seed)};
        resultIn <= resExp;
        resultUpdate <= 1'b1;
        @(posedge ref_clk);
        resultUpdate <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check(convDone, 1'b1);
    endtask
    // Hang guard
    initial begin
        repeat (90000) @(posedge ref_clk);
        err_count++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({autoMode, convDone, cfgWe}, 3'h0);
        newResults();
        for (logic [7:0] p = 8'h01; p <= 8'h04; p++) begin
            host.readReg(p, word);
            check(word, expReg(p));
            check(convDone, 1'b1);
        end
        host.writeReg(`REG_KEY, `KEY_SET, 3'h4);
        check(cfgWe, 1'b1);
        host.writeReg(`REG_KEY, $random(seed) | 32'h0001_0000, 3'h4);
        check(cfgWe, 1'b1);
        host.writeReg(`REG_KEY, `KEY_CLEAR, 3'h1);
        check(cfgWe, 1'b0);
        host.writeReg(`REG_KEY, 32'h0000_1016, 3'h2);
        check(cfgWe, 1'b1);
        host.writeReg(`REG_KEY, {8'h5a, `KEY_CLEAR}, 3'h5);
        check(cfgWe, 1'b0);
        host.writeReg(`REG_KEY, `KEY_SET, 3'h3);
        check(cfgWe, 1'b1);
        host.readReg(`REG_KEY, word);
        check(word, `WORD_ZERO);
        for (logic [7:0] p = 8'h01; p <= 8'h04; p++) begin
            host.writeReg(p, $random(seed), 3'h4);
            host.readReg(p, word);
            check(word, expReg(p));
            check({convDone, cfgWe}, 2'h3);
        end
        host.writeReg(`REG_STATUS, 32'h0000_0100, 3'h4);
        check({autoMode, convDone}, 2'h2);
        host.readReg(`REG_STATUS, word);
        check(word, (32'h1 << `BIT_AUTO) | (32'h1 << `BIT_WR_ENABLE));
        for (logic [7:0] p = 8'h01; p <= 8'h04; p++) begin
            newResults();
            host.readReg(p, word);
            check(word, expReg(p));
            check(convDone, 1'b0);
        end
        host.writeReg(`REG_STATUS, `WORD_ZERO, 3'h4);
        check(autoMode, 1'b0);
        check(convReqCount, 0);
        host.writeReg(`REG_STATUS, 32'h0000_0101, 3'h2);
        check(autoMode, 1'b1);
        check(convReqCount, 1);
        check(host.nackCount, 0);
        tally_and_finish();
    end
endmodule

/* File: src/sensor_regs_map.svh */
// Register map, field positions and key values of the sensor register bank
`ifndef SENSOR_REGS_MAP_SVH
`define SENSOR_REGS_MAP_SVH
`define REG_STATUS 8'h00
`define REG_PRES_VALUE 8'h01
`define REG_TEMP_VALUE 8'h02
`define REG_RAW_PRES 8'h03
`define REG_RAW_TEMP 8'h04
`define REG_KEY 8'h05
`define BIT_DONE 0
`define BIT_WR_ENABLE 3
`define BIT_AUTO 8
`define KEY_CLEAR 32'h0000_0000
`define KEY_SET 32'h0000_1016
`define DEV_ADDR_DEFAULT 7'h02
`define BYTES_PER_REG 3'h4
`define BITS_PER_BYTE 4'h8
`define LAST_BIT 4'h7
`define WORD_ZERO 32'h0000_0000
`endif

/* File: src/sensor_regs_pkg.sv */
// Types shared by the sensor register bank
package sensor_regs_pkg;
    // Latest results delivered by the measurement engine
    typedef struct packed {
        logic [31:0] compPres;
        logic [31:0] compTemp;
        logic [31:0] rawPres;
        logic [31:0] rawTemp;
    } result_set_t;

    // Target port sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_DEV = 4'b0001,
        ST_DEVACK = 4'b0010,
        ST_PTR = 4'b0011,
        ST_PTRACK = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_WACK = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_RACK = 4'b1000
    } port_state_t;
endpackage

/* File: src/sensor_result_and_key_regs.sv */
// Result and key registers of the pressure transducer behind its two-wire target port
// How it works
// - Register 1 returns compensated pressure, read-only
// - Result read in auto mode clears conversion flag
// - Register 2 returns compensated temperature, read-only
// - Register 3 returns raw pressure count, read-only
// - Register 4 returns raw temperature count, read-only
// - Register 5 write-only key sets/clears enable
// - Key 0 clears, key 4118 sets enable
// - Transfers of one or more bytes accepted, last four bytes kept
// - Status bit 8 enters auto-update mode
`timescale 1ns/10ps
`include "sensor_regs_map.svh"

module sensor_result_and_key_regs
    import sensor_regs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Two-wire pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut_q,
    output logic sdaOe_q,
    // Measurement engine
    input wire logic resultUpdate,
    input wire result_set_t resultIn,
    output logic autoMode_q,
    output logic convRequest_q,
    output logic convDone_q,
    output logic configWriteEnable_q
);

    // Pin synchronisers and edge history
    logic sclMeta_q, sclSync_q, sclPrev_q;
    logic sdaMeta_q, sdaSync_q, sdaPrev_q;
    // Sequencer
    port_state_t state_q, state_d;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic readDir_q;
    logic hostAck_q;
    logic [2:0] byteCnt_q;
    logic [31:0] wrWord_q;
    logic [31:0] rdWord_q;
    result_set_t results_q;

    // Pins pass two flops before any logic reads them
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sclMeta_q <= 1'b1;
            sclSync_q <= 1'b1;
            sclPrev_q <= 1'b1;
            sdaMeta_q <= 1'b1;
            sdaSync_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclMeta_q <= sclIn;
            sclSync_q <= sclMeta_q;
            sclPrev_q <= sclSync_q;
            sdaMeta_q <= sdaIn;
            sdaSync_q <= sdaMeta_q;
            sdaPrev_q <= sdaSync_q;
        end
    end

    // Bus conditions
    wire sclRise = sclSync_q && !sclPrev_q;
    wire sclFall = !sclSync_q && sclPrev_q;
    wire startCond = sclSync_q && sclPrev_q && sdaPrev_q && !sdaSync_q;
    wire stopCond = sclSync_q && sclPrev_q && !sdaPrev_q && sdaSync_q;
    wire byteDone = bitCnt_q == `BITS_PER_BYTE;
    wire rxState = state_q == ST_DEV || state_q == ST_PTR || state_q == ST_WDATA;
    wire inWrite = state_q == ST_WDATA || state_q == ST_WACK;

    // Write commit at stop or repeated start, one or more bytes, last four kept
    wire commitWr = (stopCond || startCond) && inWrite && byteCnt_q != 3'h0;
    wire commitStatus = commitWr && ptr_q == `REG_STATUS;
    wire commitKey = commitWr && ptr_q == `REG_KEY;
    wire keyClear = commitKey && wrWord_q == `KEY_CLEAR;
    wire keySet = commitKey && wrWord_q == `KEY_SET;

    // Read word is fetched when the read address byte is acknowledged
    wire readLoad = sclFall && state_q == ST_DEVACK && readDir_q;
    wire ptrIsResult = ptr_q >= `REG_PRES_VALUE && ptr_q <= `REG_RAW_TEMP;
    wire readClearsConv = readLoad && ptrIsResult && autoMode_q;
    wire statusClearConv = commitStatus && !wrWord_q[`BIT_DONE];

    // Register read decode; unmapped and write-only addresses read zero
    wire [31:0] statusWord = (32'(autoMode_q) << `BIT_AUTO)
        | (32'(configWriteEnable_q) << `BIT_WR_ENABLE) | (32'(convDone_q) << `BIT_DONE);
    logic [31:0] readMux;
    always_comb begin
        case (ptr_q)
            `REG_STATUS: readMux = statusWord;
            `REG_PRES_VALUE: readMux = results_q.compPres;
            `REG_TEMP_VALUE: readMux = results_q.compTemp;
            `REG_RAW_PRES: readMux = results_q.rawPres;
            `REG_RAW_TEMP: readMux = results_q.rawTemp;
            default: readMux = `WORD_ZERO;
        endcase
    end

    // Next sequencer state
    always_comb begin
        state_d = state_q;
        if (stopCond) begin
            state_d = ST_IDLE;
        end else if (startCond) begin
            state_d = ST_DEV;
        end else if (sclFall) begin
            case (state_q)
                ST_DEV: state_d = !byteDone ? ST_DEV
                    : (shift_q[7:1] == DEV_ADDR ? ST_DEVACK : ST_IDLE);
                ST_DEVACK: state_d = readDir_q ? ST_RDATA : ST_PTR;
                ST_PTR: state_d = byteDone ? ST_PTRACK : ST_PTR;
                ST_PTRACK: state_d = ST_WDATA;
                ST_WDATA: state_d = byteDone ? ST_WACK : ST_WDATA;
                ST_WACK: state_d = ST_WDATA;
                ST_RDATA: state_d = bitCnt_q == `LAST_BIT ? ST_RACK : ST_RDATA;
                ST_RACK: state_d = hostAck_q ? ST_RDATA : ST_IDLE;
                default: state_d = ST_IDLE;
            endcase
        end
    end

    // Sequencer registers and serial data path
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            readDir_q <= 1'b0;
            hostAck_q <= 1'b0;
            byteCnt_q <= 3'h0;
            wrWord_q <= `WORD_ZERO;
            rdWord_q <= `WORD_ZERO;
            sdaOe_q <= 1'b0;
            sdaOut_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (startCond || stopCond) begin
                bitCnt_q <= 4'h0;
                sdaOe_q <= 1'b0;
            end else if (sclRise) begin
                if (rxState) begin
                    shift_q <= {shift_q[6:0], sdaSync_q};
                    bitCnt_q <= bitCnt_q + 4'h1;
                end
                if (state_q == ST_RACK) begin
                    hostAck_q <= !sdaSync_q;
                end
            end else if (sclFall) begin
                case (state_q)
                    ST_DEV: begin
                        if (byteDone) begin
                            readDir_q <= shift_q[0];
                            sdaOe_q <= shift_q[7:1] == DEV_ADDR;
                        end
                    end
                    ST_DEVACK: begin
                        bitCnt_q <= 4'h0;
                        byteCnt_q <= 3'h0;
                        wrWord_q <= `WORD_ZERO;
                        rdWord_q <= readMux;
                        sdaOe_q <= readDir_q && !readMux[31];
                    end
                    ST_PTR: begin
                        if (byteDone) begin
                            ptr_q <= shift_q;
                            sdaOe_q <= 1'b1;
                        end
                    end
                    ST_WDATA: begin
                        if (byteDone) begin
                            wrWord_q <= {wrWord_q[23:0], shift_q};
                            if (byteCnt_q != `BYTES_PER_REG) begin
                                byteCnt_q <= byteCnt_q + 3'h1;
                            end
                            sdaOe_q <= 1'b1;
                        end
                    end
                    ST_PTRACK, ST_WACK: begin
                        bitCnt_q <= 4'h0;
                        sdaOe_q <= 1'b0;
                    end
                    ST_RDATA: begin
                        rdWord_q <= {rdWord_q[30:0], 1'b0};
                        bitCnt_q <= bitCnt_q + 4'h1;
                        sdaOe_q <= bitCnt_q != `LAST_BIT && !rdWord_q[30];
                    end
                    ST_RACK: begin
                        bitCnt_q <= 4'h0;
                        sdaOe_q <= hostAck_q && !rdWord_q[31];
                    end
                    default: sdaOe_q <= 1'b0;
                endcase
            end
        end
    end

    // Results, status flags and key; engine updates win over clears
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            results_q <= '0;
            convDone_q <= 1'b0;
            configWriteEnable_q <= 1'b0;
            autoMode_q <= 1'b0;
            convRequest_q <= 1'b0;
        end else begin
            if (resultUpdate) begin
                results_q <= resultIn;
            end
            if (resultUpdate) begin
                convDone_q <= 1'b1;
            end else if (readClearsConv || statusClearConv) begin
                convDone_q <= 1'b0;
            end
            if (keySet) begin
                configWriteEnable_q <= 1'b1;
            end else if (keyClear) begin
                configWriteEnable_q <= 1'b0;
            end
            if (commitStatus) begin
                autoMode_q <= wrWord_q[`BIT_AUTO];
            end
            convRequest_q <= commitStatus && wrWord_q[`BIT_DONE];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    chk_key_clears: assert property (keyClear |=> !configWriteEnable_q)
        else $error("key zero did not clear enable");
    chk_key_sets: assert property (keySet |=> configWriteEnable_q)
        else $error("key 4118 did not set enable");
    chk_key_other: assert property (commitKey && !keySet && !keyClear |=> $stable(configWriteEnable_q))
        else $error("other key value changed enable");
    chk_read_clear: assert property (readClearsConv && !resultUpdate |=> !convDone_q)
        else $error("result read in auto mode kept conversion flag");
    chk_ro_ignored: assert property (commitWr && ptrIsResult && !resultUpdate
        |=> $stable(convDone_q) && $stable(autoMode_q) && $stable(results_q))
        else $error("write to result register had an effect");
    chk_pres_read: assert property (readLoad && ptr_q == `REG_PRES_VALUE
        |=> rdWord_q == $past(results_q.compPres))
        else $error("pressure read returned wrong word");
    chk_temp_read: assert property (readLoad && ptr_q == `REG_TEMP_VALUE
        |=> rdWord_q == $past(results_q.compTemp))
        else $error("temperature read returned wrong word");
    chk_rawp_read: assert property (readLoad && ptr_q == `REG_RAW_PRES
        |=> rdWord_q == $past(results_q.rawPres))
        else $error("raw pressure read returned wrong word");
    chk_rawt_read: assert property (readLoad && ptr_q == `REG_RAW_TEMP
        |=> rdWord_q == $past(results_q.rawTemp))
        else $error("raw temperature read returned wrong word");
    chk_auto_mode: assert property (commitStatus |=> autoMode_q == $past(wrWord_q[`BIT_AUTO]))
        else $error("auto mode bit not taken from status write");
    chk_byte_limit: assert property (byteCnt_q <= `BYTES_PER_REG)
        else $error("byte count above four");

endmodule
